// >>> design/hka_pkg.sv
// Constants, types and timing figures shared by the housekeeping acquisition block.
package hka_pkg;

    // ==================================================================
    // Clock and rates
    // ==================================================================
    // System clock rate, a power of two so that the time base divides evenly.
    localparam int CLK_HZ = 262144;
    // Nanoseconds in one second, used to turn times into cycle counts.
    localparam longint NS_PER_S = 64'd1000000000;
    // Sun-sensor oversampling rate and the matching number of cycles per tick.
    localparam int QUARTER_HZ = 4;
    localparam int QUARTER_CYC = CLK_HZ / QUARTER_HZ;
    // Down-link bit rate and the number of cycles per bit.
    localparam int DOWNLINK_BPS = 32768;
    localparam int BIT_CYC = CLK_HZ / DOWNLINK_BPS;
    // Fastest asynchronous input and the least oversampling it needs.
    localparam int ASYNC_MAX_BPS = 19200;
    localparam int MIN_OVERSAMPLE = 3;
    localparam bit OVERSAMPLE_OK = (CLK_HZ >= ASYNC_MAX_BPS * MIN_OVERSAMPLE);

    // ==================================================================
    // Converter handshake timing
    // ==================================================================
    // Least time each converter phase (address setup, latch, start) lasts.
    localparam longint PHASE_NS = 64'd20000;
    // Least time rounds up to whole cycles, never below one.
    localparam longint PHASE_RAW =
        (PHASE_NS * 64'(CLK_HZ) + NS_PER_S - 64'd1) / NS_PER_S;
    localparam int PHASE_CYC = (PHASE_RAW < 64'd1) ? 1 : int'(PHASE_RAW);
    localparam int PHASE_W = 8;

    // ==================================================================
    // Packet layout
    // ==================================================================
    localparam int OCT_W = 6;
    // First octet of the telecommand status reports and their count.
    localparam logic [OCT_W-1:0] OCT_REPORT_FIRST = 6'h09;
    localparam int REPORT_OCTETS = 6;
    localparam int REPORT_BITS = 48;
    // First analogue octet and the size of one analogue plus sun-sensor block.
    localparam logic [OCT_W-1:0] OCT_ANALOG_FIRST = 6'h0F;
    localparam int BLOCK_OCTETS = 3;
    localparam int NUM_CHANNELS = 16;
    localparam int CH_W = 4;
    // Depth of the octet FIFO.
    localparam int FIFO_DEPTH = 4;

    // One data-field octet together with its position in the packet.
    typedef struct packed {
        logic [OCT_W-1:0] index;
        logic [7:0] data;
    } hka_octet_s;

    // Sequencer states, Gray coded in the order they are declared.
    typedef enum logic [2:0] {
        HKA_IDLE = 3'h0,
        HKA_REPORT = 3'h1,
        HKA_SETUP = 3'h3,
        HKA_ALE = 3'h2,
        HKA_START = 3'h6,
        HKA_CONVERT = 3'h7,
        HKA_STORE = 3'h5
    } hka_state_e;

    // Reverses an octet so that bit 0 of a bus becomes the most significant bit.
    function automatic logic [7:0] hka_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[7-i] = v[i];
        end
        return r;
    endfunction : hka_rev8

endpackage : hka_pkg

// >>> design/hka_fifo.sv
// Small valid/ready FIFO that buffers packet octets.
`timescale 1ns/1ps
module hka_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    // Storage array and pointers.
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    // Handshake decode.
    wire logic do_push = in_valid && in_ready;
    wire logic do_pop = out_valid && out_ready;
    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // Pointers wrap at the last slot and the count follows push and pop.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end

    // The array itself has no reset; only written slots are ever read.
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : hka_fifo

// >>> design/hka_acq.sv
// Housekeeping packet acquisition: status reports, analogue and sun-sensor octets.
`timescale 1ns/1ps
// How it works
// [RULE1] Status reports fill data-field octets nine to fourteen.
// [RULE2] First received report bit lands most significant.
// [RULE3] Channel k sampled per quarter second into 15+3k.
// [RULE4] Converter bus bit zero is the MSB.
// [RULE5] Sun sensors sampled four times a second.
// [RULE6] Sun-sensor inputs pass one register stage first.
// [RULE7] All sixteen sun inputs captured together, two octets.
// [RULE8] Toggle flip-flop flips on each strobe rising edge.
// [RULE9] Toggle state drives a dedicated level output.
// [RULE10] Logic runs from a 262144 Hz system clock.
// [RULE11] Clock oversamples 19200 bit/s input at least threefold.
// [RULE12] Down-link bit rate is 32768 bit/s.
// [RULE13] One packet every four seconds, aligned ticks.
// [RULE14] Address, latch pulse, start pulse, read after done.
// [RULE15] Reports read once per packet, held stable.
module hka_acq
    import hka_pkg::*;
#(
    parameter int QUARTER_CYCLES = QUARTER_CYC,
    parameter int BIT_CYCLES = BIT_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Telecommand decoder status reports, bit 15 received first.
    input wire logic [15:0] command_unit_report,
    input wire logic [15:0] first_acceptance_report,
    input wire logic [15:0] second_acceptance_report,
    output logic report_capture,
    // Analogue converter.
    output logic [CH_W-1:0] analog_mux_select,
    output logic analog_address_latch,
    output logic analog_conversion_start,
    input wire logic analog_conversion_done,
    input wire logic [7:0] analog_sample_bus,
    // Sun sensors.
    input wire logic [15:0] sun_sensor_inputs,
    // Time strobe conditioning.
    input wire logic time_strobe_in,
    output logic time_strobe_toggle_out,
    // Time base outputs.
    output logic quarter_tick,
    output logic downlink_bit_tick,
    // Octet stream towards the packet serialiser.
    output logic octet_valid,
    input wire logic octet_ready,
    output logic [OCT_W-1:0] octet_index,
    output logic [7:0] octet_data
);
    localparam int QW = $clog2(QUARTER_CYCLES + 1);
    localparam int BW = $clog2(BIT_CYCLES + 1);
    localparam logic [QW-1:0] Q_LAST = QW'(QUARTER_CYCLES - 1);
    localparam logic [BW-1:0] B_LAST = BW'(BIT_CYCLES - 1);
    localparam logic [PHASE_W-1:0] PH_LAST = PHASE_W'(PHASE_CYC - 1);
    localparam logic [2:0] REP_LAST = 3'(REPORT_OCTETS - 1);
    localparam logic [1:0] SUB_LAST = 2'(BLOCK_OCTETS - 1);
    localparam logic [CH_W-1:0] CH_LAST = CH_W'(NUM_CHANNELS - 1);
    localparam int FW = $bits(hka_octet_s);

    // ==================================================================
    // Time base
    // ==================================================================
    logic [QW-1:0] q_cnt;      // Cycles within the current quarter second.
    logic [BW-1:0] b_cnt;      // Cycles within the current down-link bit.
    logic tick;                // Internal quarter-second pulse.
    assign tick = (q_cnt == Q_LAST);
    // Both dividers count the same clock, so ticks stay on whole quarters.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_cnt <= '0;
            b_cnt <= '0;
            quarter_tick <= 1'b0;
            downlink_bit_tick <= 1'b0;
        end else begin
            q_cnt <= tick ? '0 : q_cnt + 1'b1;                   // see [RULE5] see [RULE13]
            b_cnt <= (b_cnt == B_LAST) ? '0 : b_cnt + 1'b1;      // see [RULE12]
            quarter_tick <= tick;
            downlink_bit_tick <= (b_cnt == B_LAST);              // see [RULE12] see [RULE10]
        end
    end

    // ==================================================================
    // Input stages and time strobe toggle
    // ==================================================================
    logic [15:0] sun_q;         // Registered sun-sensor inputs.
    logic strobe_q;             // Previous time strobe level.
    wire logic strobe_rise = time_strobe_in && !strobe_q;
    // Sun inputs get one register stage; the strobe edge flips the toggle.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sun_q <= '0;
            strobe_q <= 1'b0;
            time_strobe_toggle_out <= 1'b0;
        end else begin
            sun_q <= sun_sensor_inputs;                                  // see [RULE6]
            strobe_q <= time_strobe_in;
            if (strobe_rise) begin
                time_strobe_toggle_out <= !time_strobe_toggle_out;      // see [RULE8] see [RULE9]
            end
        end
    end

    // ==================================================================
    // Sequencer
    // ==================================================================
    hka_state_e state;
    hka_state_e next_state;
    logic [PHASE_W-1:0] ph_cnt;         // Cycles spent in a timed phase.
    logic [2:0] rep_idx;                // Report octet being pushed.
    logic [1:0] sub_idx;                // Octet within a sample block.
    logic [CH_W-1:0] ch;                // Analogue channel of this sample.
    logic report_due;                   // Reports still owed for the first packet after reset.
    logic tick_pend;                    // Quarter tick waiting for the sequencer.
    logic [REPORT_BITS-1:0] rep_snap;   // Stable copy of the status reports.
    logic [7:0] adc_hold;               // Converted analogue octet.
    logic [15:0] sun_hold;              // Sun-sensor snapshot of this tick.

    // FIFO handshake towards the sequencer.
    logic push_ready;
    wire logic push_valid = (state == HKA_REPORT) || (state == HKA_STORE);
    wire logic push_fire = push_valid && push_ready;
    wire logic ph_done = (ph_cnt == PH_LAST);
    wire logic conv_read = (state == HKA_CONVERT) && ph_done && analog_conversion_done;
    wire logic take_tick = (state == HKA_IDLE) && tick_pend;
    wire logic last_store = (state == HKA_STORE) && push_fire && (sub_idx == SUB_LAST);
    wire logic capture_rep = (take_tick && report_due) || (last_store && (ch == CH_LAST));

    // Octet selection for the push side.
    wire logic [7:0] rep_octet = rep_snap[(REPORT_BITS - 1) - 8 * rep_idx -: 8];  // see [RULE2]
    wire logic [OCT_W-1:0] rep_pos = OCT_REPORT_FIRST + OCT_W'(rep_idx);         // see [RULE1]
    wire logic [OCT_W-1:0] blk_pos =
        OCT_ANALOG_FIRST + OCT_W'(ch) * OCT_W'(BLOCK_OCTETS) + OCT_W'(sub_idx);   // see [RULE3]
    wire logic [7:0] sun_first = hka_rev8(sun_hold[7:0]);                        // see [RULE7]
    wire logic [7:0] sun_second = hka_rev8(sun_hold[15:8]);                      // see [RULE7]
    wire logic [7:0] blk_octet = (sub_idx == 2'd0) ? adc_hold :
                                 (sub_idx == 2'd1) ? sun_first : sun_second;
    hka_octet_s push_word;
    assign push_word.index = (state == HKA_REPORT) ? rep_pos : blk_pos;
    assign push_word.data = (state == HKA_REPORT) ? rep_octet : blk_octet;
    // The three timed converter phases follow one another in a fixed order.
    hka_state_e phase_next;
    assign phase_next = (state == HKA_SETUP) ? HKA_ALE :
                        (state == HKA_ALE) ? HKA_START : HKA_CONVERT;

    // Next-state decode; HKA_IDLE waits on a pending tick, HKA_CONVERT on the phase timer and converter done, every other step on the FIFO or the phase timer.
    always_comb begin
        next_state = state;
        case (state)
            HKA_IDLE: begin
                if (take_tick) begin
                    next_state = report_due ? HKA_REPORT : HKA_SETUP;
                end
            end
            HKA_REPORT: begin
                if (push_fire && rep_idx == REP_LAST) begin
                    next_state = HKA_IDLE;
                end
            end
            HKA_SETUP, HKA_ALE, HKA_START: begin
                if (ph_done) begin
                    next_state = phase_next;                          // see [RULE14]
                end
            end
            HKA_CONVERT: begin
                if (conv_read) begin
                    next_state = HKA_STORE;                           // see [RULE14]
                end
            end
            HKA_STORE: begin
                if (last_store) begin
                    next_state = (ch == CH_LAST) ? HKA_REPORT : HKA_IDLE;
                end
            end
            default: begin
                next_state = HKA_IDLE;
            end
        endcase
    end

    // State, phase timer and octet counters.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= HKA_IDLE;
            ph_cnt <= '0;
            rep_idx <= '0;
            sub_idx <= '0;
        end else begin
            state <= next_state;
            ph_cnt <= (next_state != state || ph_done) ? '0 : ph_cnt + 1'b1;
            if (state == HKA_REPORT && push_fire) begin
                rep_idx <= (rep_idx == REP_LAST) ? '0 : rep_idx + 1'b1;
            end
            if (state == HKA_STORE && push_fire) begin
                sub_idx <= (sub_idx == SUB_LAST) ? '0 : sub_idx + 1'b1;
            end
        end
    end

    // Packet bookkeeping: pending tick, channel number, report snapshot.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_pend <= 1'b0;
            report_due <= 1'b1;
            ch <= '0;
            rep_snap <= '0;
            report_capture <= 1'b0;
        end else begin
            // A new tick wins over the consumption of the previous one.
            tick_pend <= tick || (tick_pend && !take_tick);
            if (take_tick && report_due) begin
                report_due <= 1'b0;
            end
            if (last_store) begin
                ch <= (ch == CH_LAST) ? '0 : ch + 1'b1;              // see [RULE13]
            end
            if (capture_rep) begin
                rep_snap <= {command_unit_report, first_acceptance_report,
                             second_acceptance_report};               // see [RULE15]
            end
            report_capture <= capture_rep;
        end
    end

    // Sample capture: all sun inputs at the tick, converter octet after done.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sun_hold <= '0;
            adc_hold <= '0;
        end else begin
            if (take_tick && !report_due) begin
                sun_hold <= sun_q;                                     // see [RULE7] see [RULE5]
            end
            if (conv_read) begin
                adc_hold <= hka_rev8(analog_sample_bus);               // see [RULE4]
            end
        end
    end

    // Converter pins come from flops, decoded from the next state.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_mux_select <= '0;
            analog_address_latch <= 1'b0;
            analog_conversion_start <= 1'b0;
        end else begin
            if (next_state == HKA_SETUP) begin
                analog_mux_select <= ch;                               // see [RULE3]
            end
            analog_address_latch <= (next_state == HKA_ALE);           // see [RULE14]
            analog_conversion_start <= (next_state == HKA_START);      // see [RULE14]
        end
    end

    // ==================================================================
    // Octet buffer and registered output stage
    // ==================================================================
    logic fifo_valid;
    hka_octet_s fifo_word;
    wire logic out_take = !octet_valid || octet_ready;

    hka_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(fifo_valid),
        .out_ready(out_take),
        .out_data(fifo_word)
    );

    // The output register reloads whenever it is empty or being taken.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            octet_valid <= 1'b0;
            octet_index <= '0;
            octet_data <= '0;
        end else if (out_take) begin
            octet_valid <= fifo_valid;
            if (fifo_valid) begin
                octet_index <= fifo_word.index;
                octet_data <= fifo_word.data;
            end
        end
    end

    // ==================================================================
    // Checks
    // ==================================================================
    a_report_slots: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE1]
        (state == HKA_REPORT && push_fire) |->
            (push_word.index >= OCT_REPORT_FIRST && push_word.index <= 6'h0E))
        else $error("report octet outside its slots");
    a_report_msb_first: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE2]
        (state == HKA_REPORT && push_fire && rep_idx == 3'd0) |->
            (push_word.index == 6'h09 && push_word.data == rep_snap[47:40]))
        else $error("first report octet not the earliest bits");
    a_analog_slot: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE3]
        (state == HKA_STORE && push_fire && sub_idx == 2'd0) |->
            (push_word.index == 6'(6'h0F + 6'(ch) * 6'd3) && analog_mux_select == ch))
        else $error("analogue octet in wrong slot");
    a_adc_bit_order: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE4]
        conv_read |=> (adc_hold == hka_rev8($past(analog_sample_bus))))
        else $error("converter bits not reversed");
    a_tick_spacing: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE5]
        tick |=> (q_cnt == '0 && quarter_tick && tick_pend))
        else $error("quarter tick not taken up");
    a_sun_stage: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE6]
        (take_tick && !report_due) ##1 (state != HKA_IDLE) |->
            (sun_hold == $past(sun_sensor_inputs, 2)))
        else $error("sun snapshot not one stage late");
    a_toggle_edge: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE8]
        $rose(time_strobe_in) |=> (time_strobe_toggle_out != $past(time_strobe_toggle_out)))
        else $error("toggle missed strobe edge");
    a_toggle_hold: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE9]
        !strobe_rise |=> $stable(time_strobe_toggle_out))
        else $error("toggle changed without edge");
    a_bit_rate: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE12]
        downlink_bit_tick |=> (!downlink_bit_tick)[*7] ##1 downlink_bit_tick)
        else $error("bit tick spacing wrong");
    a_conv_order: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE14]
        $rose(analog_conversion_start) |-> ($past(analog_address_latch) && $stable(analog_mux_select)))
        else $error("start without prior latch");
    a_report_hold: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE15]
        !capture_rep |=> $stable(rep_snap))
        else $error("report snapshot changed mid packet");
    a_clock_oversample: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE11]
        OVERSAMPLE_OK)
        else $error("clock too slow to oversample serial input");

endmodule : hka_acq

// >>> testbench/hka_adc_model.sv
// Behavioural model of the multiplexed analogue converter beside the block.
`timescale 1ns/1ps
module hka_adc_model (
    // Clock.
    input wire logic clk,
    // Control from the block.
    input wire logic [3:0] analog_mux_select,
    input wire logic analog_address_latch,
    input wire logic analog_conversion_start,
    // Answer to the block.
    output logic analog_conversion_done,
    output logic [7:0] analog_sample_bus
);
    logic [3:0] chan = 4'h0; // Channel taken while the latch pulse is high.
    int wait_cyc = 0; // Cycles left before the result is offered.
    logic busy = 1'b0; // A conversion is running.
    initial analog_conversion_done = 1'b0;
    initial analog_sample_bus = 8'h00;
    // Odd channels answer promptly, even ones slowly; stale data flips each cycle the start pulse is high.
    always @(posedge clk) begin
        if (analog_address_latch) begin
            chan <= analog_mux_select;
        end
        if (analog_conversion_start) begin
            analog_conversion_done <= 1'b0;
            analog_sample_bus <= ~analog_sample_bus;
            busy <= 1'b1;
            wait_cyc <= chan[0] ? 3 : 30;
        end else if (busy && wait_cyc > 0) begin
            wait_cyc <= wait_cyc - 1;
        end else if (busy) begin
            busy <= 1'b0;
            analog_conversion_done <= 1'b1;
            analog_sample_bus <= {chan, ~chan};
        end
    end
endmodule : hka_adc_model

// >>> testbench/tb.sv
// Self-checking bench for the housekeeping acquisition block.
`timescale 1ns/1ps
module tb;
    import hka_pkg::*;
    localparam int QC = 200; // Shortened quarter-second period.
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] rep_a = 16'h0000, rep_b = 16'h0000, rep_c = 16'h0000, sun = 16'h0000;
    logic strobe = 1'b0, ready = 1'b0, exp_tog = 1'b0;
    logic cap, ale, start, done, toggle, qtick, btick, ovalid;
    logic [3:0] sel, ch;
    logic [7:0] bus, odat, an, s0, s1;
    logic [5:0] oidx, base;
    bit bseen = 1'b0;
    logic [47:0] rep;
    hka_octet_s e;
    hka_octet_s exp_q[$]; // Expected octets in stream order.
    int err_count = 0, checks = 0, cyc = 0, ticks = 0, since = 0, bgap = 0;

    always #50 clk = ~clk;

    hka_acq #(.QUARTER_CYCLES(QC)) uut (.clk(clk), .arst_n(arst_n),
        .command_unit_report(rep_a), .first_acceptance_report(rep_b),
        .second_acceptance_report(rep_c), .report_capture(cap), .analog_mux_select(sel),
        .analog_address_latch(ale), .analog_conversion_start(start),
        .analog_conversion_done(done), .analog_sample_bus(bus), .sun_sensor_inputs(sun),
        .time_strobe_in(strobe), .time_strobe_toggle_out(toggle), .quarter_tick(qtick),
        .downlink_bit_tick(btick), .octet_valid(ovalid), .octet_ready(ready),
        .octet_index(oidx), .octet_data(odat));

    hka_adc_model adc (.clk(clk), .analog_mux_select(sel), .analog_address_latch(ale),
        .analog_conversion_start(start), .analog_conversion_done(done),
        .analog_sample_bus(bus));

    // Counts and reports one mismatch.
    task automatic fail(input string msg);
        err_count++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : fail

    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // Checks the spacing of the quarter ticks and of the down-link bit ticks.
    always @(posedge clk) begin
        since++;
        bgap++;
        if (qtick === 1'b1) begin
            ticks++;
            checks++;
            if (ticks > 1 && since != QC) fail("tick spacing");
            since = 0;
        end
        if (btick === 1'b1) begin
            if (bseen) begin
                checks++;
                if (bgap != BIT_CYC) fail("bit tick spacing");
            end
            bseen = 1'b1;
            bgap = 0;
        end
    end

    // Compares each octet taken from the stream with the oldest note.
    always @(posedge clk) begin
        if (arst_n && ovalid === 1'b1 && ready) begin
            checks++;
            if (exp_q.size() == 0) begin
                fail("octet with nothing expected");
            end else begin
                e = exp_q.pop_front();
                if ({oidx, odat} !== e) fail("wrong octet");
            end
        end
    end

    // Drives stalls, reports, sun data and strobes, and notes the octets owed.
    always @(negedge clk) begin
        ready = ($urandom % 4) == 0;
        if (cap === 1'b1) begin
            rep = {rep_a, rep_b, rep_c};
            for (int i = 0; i < 6; i++) begin
                exp_q.push_back('{OCT_REPORT_FIRST + 6'(i), rep[47 - 8 * i -: 8]});
            end
            rep_a = 16'($urandom);
            rep_b = 16'($urandom);
            rep_c = 16'($urandom);
        end
        if (qtick === 1'b1 && ticks > 0) begin
            ch = 4'((ticks - 1) % 16);
            base = OCT_ANALOG_FIRST + 6'(3 * ch);
            an = {<<{ch, ~ch}};
            s0 = {<<{sun[7:0]}};
            s1 = {<<{sun[15:8]}};
            exp_q.push_back('{base, an});
            exp_q.push_back('{base + 6'h01, s0});
            exp_q.push_back('{base + 6'h02, s1});
        end
        if (since == QC / 2) sun = 16'($urandom);
        if (since == 20) begin
            strobe = 1'b1;
            exp_tog = ~exp_tog;
        end
        if (since == 23) strobe = 1'b0;
        if (since == 30 && ticks > 0) begin
            checks++;
            if (toggle !== exp_tog) fail("toggle level");
        end
    end

    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 9000) begin
            fail("timeout");
            complete_run();
        end
    end

    // Main sequence: reset, two whole packets and more, then drain.
    initial begin
        void'($urandom(32'hFB41));
        repeat (4) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        wait (ticks == 35);
        repeat (QC - 20) @(posedge clk);
        if (exp_q.size() != 0) fail("octets missing");
        complete_run();
    end
endmodule : tb
